/* design/ppf_pkg.sv */
package ppf_pkg;

	// register addresses on the host bus
	localparam logic [1:0] PPF_ADDR_PORT   = 2'h0;
	localparam logic [1:0] PPF_ADDR_STATUS = 2'h1;
	localparam logic [1:0] PPF_ADDR_PINS   = 2'h2;
	localparam logic [1:0] PPF_ADDR_EXTRA  = 2'h3;

	// pin drive register fields
	localparam int PPF_CON_STROBE = 0;
	localparam int PPF_CON_AUTO   = 1;
	localparam int PPF_CON_INIT   = 2;
	localparam int PPF_CON_CHOOSE = 3;
	localparam int PPF_CON_IRQEN  = 4;
	localparam int PPF_CON_DIR    = 5;

	// extra function register fields
	localparam int PPF_AFR_HS     = 3;
	localparam int PPF_AFR_TYPE   = 4;
	localparam int PPF_AFR_POL    = 6;
	localparam int PPF_AFR_FEN    = 7;

	localparam logic [7:0] PPF_CON_RESET  = 8'h00;
	localparam logic [7:0] PPF_AFR_RESET  = 8'h00;
	localparam logic [7:0] PPF_DATA_RESET = 8'h00;
	// error,online,paper,busy,ack,mode,strobe,auto,init,choose,data
	localparam logic [17:0] PPF_PIN_SYNC_RESET = 18'h3FDFF;

	localparam int PPF_FIFO_DEPTH = 83;

	// strobe delay and width in clocks, indexed by timing select
	localparam logic [7:0][4:0] PPF_DELAY_TBL = {5'h09, 5'h05, 5'h05, 5'h03,
		5'h12, 5'h0A, 5'h0A, 5'h06};
	localparam logic [7:0][4:0] PPF_WIDTH_TBL = {5'h08, 5'h04, 5'h04, 5'h02,
		5'h10, 5'h08, 5'h08, 5'h04};

	localparam logic [1:0] PPF_IRQ_NORMAL = 2'h0;
	localparam logic [1:0] PPF_IRQ_EMPTY  = 2'h1;
	localparam logic [1:0] PPF_IRQ_FULL   = 2'h2;
	localparam logic [1:0] PPF_IRQ_EMPTYB = 2'h3;

	typedef enum logic [3:0] {
		PPF_IDLE  = 4'h1,
		PPF_DELAY = 4'h2,
		PPF_WIDTH = 4'h4,
		PPF_WAIT  = 4'h8
	} ppf_engine_type;

endpackage

/* design/ppf_printer_port.sv */
// Functional notes
// - fifo off at reset; mode after first handshake
// - fifo mode until init low; init change clears
// - 83-byte fifo drains at printer pace
// - init low: port read pops, strobe high
// - outside fifo mode strobe from pin drive
// - fifo mode: strobe generated, bit0 ignored
// - timing select sets strobe delay and width
// - handshake source ack or busy
// - count up on write, down on handshake
// - count settles within five clocks of edge
// - write into full fifo dropped
// - latched interrupt set by strobe bit or handshake, cleared by status read
// - pulse interrupt set by strobe bit, cleared by port write
// - status shows ack level and latched interrupt
// - extra bit 6 inverts interrupt polarity
// - extra bits 5..4 choose interrupt source
// - status bits 1..0 one unless type three
// - status shows error, online, paper levels
// - status bit7: not full or not busy
// - port data out/in by direction, output at reset
// - readback shows pin levels and mask
// - pin drive register sets pins and direction

module ppf_sync #(
	parameter int           W         = 1,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] asyncIn,
	output logic      [W-1:0] level
);
	logic [W-1:0] s1Reg;
	logic [W-1:0] s2Reg;
	logic [W-1:0] s3Reg;
	logic [W-1:0] levelReg;
	wire  [W-1:0] agree = ~(s2Reg ^ s3Reg);
	wire  [W-1:0] levelNext = (agree & s2Reg) | (~agree & levelReg);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1Reg    <= RESET_VAL;
			s2Reg    <= RESET_VAL;
			s3Reg    <= RESET_VAL;
			levelReg <= RESET_VAL;
		end else begin
			s1Reg    <= asyncIn;
			s2Reg    <= s1Reg;
			s3Reg    <= s2Reg;
			levelReg <= levelNext;
		end
	end
	assign level = levelReg;
endmodule // ppf_sync

module ppf_fifo
	import ppf_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = PPF_FIFO_DEPTH,
	parameter int CW    = $clog2(DEPTH + 1),
	parameter int PW    = $clog2(DEPTH)
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic             clear,
	input  wire logic             inValid,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  inReady,
	output logic                  outValid,
	output logic      [WIDTH-1:0] outData,
	input  wire logic             outReady,
	output logic      [CW-1:0]    count
);
	logic [WIDTH-1:0] memReg [DEPTH];
	logic [PW-1:0]    wrPtrReg;
	logic [PW-1:0]    rdPtrReg;
	logic [CW-1:0]    countReg;
	wire              doPush = inValid & inReady;
	wire              doPop = outValid & outReady;
	wire  [PW-1:0]    wrPtrNext = (wrPtrReg == PW'(DEPTH - 1)) ? '0 : wrPtrReg + 1'b1;
	wire  [PW-1:0]    rdPtrNext = (rdPtrReg == PW'(DEPTH - 1)) ? '0 : rdPtrReg + 1'b1;

	assign inReady  = countReg != CW'(DEPTH);
	assign outValid = countReg != '0;
	assign outData  = memReg[rdPtrReg];
	assign count    = countReg;

	always_ff @(posedge clk) begin
		if (doPush) begin
			memReg[wrPtrReg] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtrReg <= '0;
			rdPtrReg <= '0;
			countReg <= '0;
		end else if (clear) begin
			wrPtrReg <= '0;
			rdPtrReg <= '0;
			countReg <= '0;
		end else begin
			if (doPush) wrPtrReg <= wrPtrNext;
			if (doPop) rdPtrReg <= rdPtrNext;
			if (doPush && !doPop) countReg <= countReg + 1'b1;
			else if (doPop && !doPush) countReg <= countReg - 1'b1;
		end
	end
endmodule // ppf_fifo

module ppf_printer_port
	import ppf_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       csN,
	input  wire logic       hostReadN,
	input  wire logic       hostWriteN,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] hostDataIn,
	output logic      [7:0] hostDataOut,
	output logic            hostDataOeN,
	input  wire logic [7:0] printerDataPinsIn,
	output logic      [7:0] printerDataPinsOut,
	output logic            printerDataPinsOeN,
	input  wire logic       strobeNIn,
	output logic            strobeNOut,
	output logic            strobeOeN,
	input  wire logic       autoLineFeedNIn,
	output logic            autoLineFeedNOut,
	output logic            autoLineFeedOeN,
	input  wire logic       initIn,
	output logic            initOut,
	output logic            initOeN,
	input  wire logic       printerChooseNIn,
	output logic            printerChooseNOut,
	output logic            printerChooseOeN,
	input  wire logic       errorN,
	input  wire logic       printerOnline,
	input  wire logic       paperOut,
	input  wire logic       busy,
	input  wire logic       ackN,
	input  wire logic       irqLatchModePin,
	output logic            irqOut,
	output logic            irqOeN
);
	localparam int CW = $clog2(PPF_FIFO_DEPTH + 1);

	logic [11:0]    busLvl;
	logic [17:0]    pinLvl;
	logic           rdPrevReg;
	logic           wrPrevReg;
	logic           ackPrevReg;
	logic           busyPrevReg;
	logic           initPrevReg;
	logic [7:0]     conReg;
	logic [7:0]     afrReg;
	logic [7:0]     dataLatchReg;
	logic           armedReg;
	logic           fifoModeReg;
	logic           pendLatchedReg;
	logic           pendPulseReg;
	ppf_engine_type stateReg;
	logic [4:0]     cntReg;
	logic [7:0]     hostDataOutReg;
	logic           hostDataOeNReg;
	logic           strobeOeNReg;
	logic           autoOeNReg;
	logic           initOeNReg;
	logic           chooseOeNReg;
	logic           dataOeNReg;
	logic           irqReg;
	logic           irqOeNReg;
	logic           fifoInReady;
	logic           fifoOutValid;
	logic [7:0]     fifoHead;
	logic [CW-1:0]  fifoCount;

	ppf_sync #(.W(12), .RESET_VAL(12'h000)) u_busSync (
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn ({~csN & ~hostReadN, ~csN & ~hostWriteN, addr, hostDataIn}),
		.level   (busLvl)
	);

	ppf_sync #(.W(18), .RESET_VAL(PPF_PIN_SYNC_RESET)) u_pinSync (
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn ({errorN, printerOnline, paperOut, busy, ackN, irqLatchModePin,
			strobeNIn, autoLineFeedNIn, initIn, printerChooseNIn, printerDataPinsIn}),
		.level   (pinLvl)
	);

	// filtered levels
	wire       rdLvl = busLvl[11];
	wire       wrLvl = busLvl[10];
	wire [1:0] busAddr = busLvl[9:8];
	wire [7:0] busData = busLvl[7:0];
	wire       errorLvl = pinLvl[17];
	wire       onlineLvl = pinLvl[16];
	wire       paperLvl = pinLvl[15];
	wire       busyLvl = pinLvl[14];
	wire       ackLvl = pinLvl[13];
	wire       modeLvl = pinLvl[12];
	wire       strobeLvl = pinLvl[11];
	wire       autoLvl = pinLvl[10];
	wire       initLvl = pinLvl[9];
	wire       chooseLvl = pinLvl[8];
	wire [7:0] dataPinLvl = pinLvl[7:0];

	// bus decode
	wire rdStart = rdLvl & ~rdPrevReg;
	wire wrStart = wrLvl & ~wrPrevReg;
	wire portWrite = wrStart & (busAddr == PPF_ADDR_PORT);
	wire conWrite = wrStart & (busAddr == PPF_ADDR_PINS);
	wire afrWrite = wrStart & (busAddr == PPF_ADDR_EXTRA);
	wire portRead = rdStart & (busAddr == PPF_ADDR_PORT);
	wire statusRead = rdStart & (busAddr == PPF_ADDR_STATUS);

	// handshake edges
	wire ackFall = ackPrevReg & ~ackLvl;
	wire busyFall = busyPrevReg & ~busyLvl;
	wire busyRise = ~busyPrevReg & busyLvl;
	wire hsFall = afrReg[PPF_AFR_HS] ? busyFall : ackFall;
	wire initLow = ~initLvl;
	wire initEdge = initLvl ^ initPrevReg;
	wire fifoEn = afrReg[PPF_AFR_FEN];

	// fifo traffic
	wire fifoPush = portWrite & fifoEn & (fifoModeReg | initLow);
	wire enginePop = (stateReg == PPF_WAIT) & hsFall;
	wire readPop = portRead & initLow & fifoEn;
	wire fifoPop = enginePop | readPop;
	wire startByte = (stateReg == PPF_IDLE) & fifoModeReg & fifoOutValid & ~initLow;
	wire [2:0] timeSel = afrReg[2:0];
	wire [4:0] delayClks = PPF_DELAY_TBL[timeSel];
	wire [4:0] widthClks = PPF_WIDTH_TBL[timeSel];

	// strobe source
	wire engineStrobe = stateReg == PPF_WIDTH;
	wire strobeWant = initLow ? 1'b0 :
		fifoModeReg ? engineStrobe : conReg[PPF_CON_STROBE];

	// interrupt source
	wire pendSet = conWrite & busData[PPF_CON_STROBE];
	wire normalAssert = modeLvl ? pendPulseReg : pendLatchedReg;
	wire [1:0] irqType = afrReg[PPF_AFR_TYPE+1:PPF_AFR_TYPE];
	wire irqAssert = (irqType == PPF_IRQ_NORMAL) ? normalAssert :
		(irqType == PPF_IRQ_FULL) ? ~fifoInReady : ~fifoOutValid;
	wire irqNext = afrReg[PPF_AFR_POL] ? irqAssert : ~irqAssert;

	// read paths
	wire statusBit7 = fifoEn ? fifoInReady : ~busyLvl;
	wire [1:0] statusLow = (irqType == PPF_IRQ_EMPTYB) ? 2'h0 : 2'h3;
	wire [7:0] statusByte = {statusBit7, ackLvl, paperLvl, onlineLvl, errorLvl,
		~pendLatchedReg, statusLow};
	wire [7:0] readbackByte = {3'h7, conReg[PPF_CON_IRQEN], ~chooseLvl, initLvl,
		~autoLvl, ~strobeLvl};
	wire [7:0] portByte = (initLow & fifoEn) ? fifoHead :
		conReg[PPF_CON_DIR] ? dataPinLvl : dataLatchReg;
	wire [7:0] countByte = {~fifoEn, fifoCount};
	wire [7:0] readMux = (busAddr == PPF_ADDR_PORT) ? portByte :
		(busAddr == PPF_ADDR_STATUS) ? statusByte :
		(busAddr == PPF_ADDR_PINS) ? readbackByte : countByte;

	ppf_fifo #(.WIDTH(8), .DEPTH(PPF_FIFO_DEPTH)) u_fifo (
		.clk      (clk),
		.rst_b    (rst_b),
		.clear    (initEdge),
		.inValid  (fifoPush),
		.inData   (busData),
		.inReady  (fifoInReady),
		.outValid (fifoOutValid),
		.outData  (fifoHead),
		.outReady (fifoPop),
		.count    (fifoCount)
	);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdPrevReg   <= 1'b0;
			wrPrevReg   <= 1'b0;
			ackPrevReg  <= 1'b1;
			busyPrevReg <= 1'b1;
			initPrevReg <= 1'b0;
		end else begin
			rdPrevReg   <= rdLvl;
			wrPrevReg   <= wrLvl;
			ackPrevReg  <= ackLvl;
			busyPrevReg <= busyLvl;
			initPrevReg <= initLvl;
		end
	end

	// host registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			conReg <= PPF_CON_RESET;
			afrReg <= PPF_AFR_RESET;
		end else begin
			if (conWrite) conReg <= busData;
			if (afrWrite) afrReg <= busData;
		end
	end

	// fifo mode entry and exit
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armedReg    <= 1'b0;
			fifoModeReg <= 1'b0;
		end else if (initLow || !fifoEn) begin
			armedReg    <= 1'b0;
			fifoModeReg <= 1'b0;
		end else begin
			if (pendSet) armedReg <= 1'b1;
			if (armedReg && (ackFall || busyRise)) fifoModeReg <= 1'b1;
		end
	end

	// strobe engine
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stateReg <= PPF_IDLE;
			cntReg   <= 5'h00;
		end else if (!fifoModeReg) begin
			stateReg <= PPF_IDLE;
			cntReg   <= 5'h00;
		end else begin
			case (stateReg)
				PPF_IDLE: begin
					if (startByte) begin
						cntReg   <= delayClks - 5'h01;
						stateReg <= PPF_DELAY;
					end
				end
				PPF_DELAY: begin
					if (cntReg == 5'h00) begin
						cntReg   <= widthClks - 5'h01;
						stateReg <= PPF_WIDTH;
					end else begin
						cntReg <= cntReg - 5'h01;
					end
				end
				PPF_WIDTH: begin
					if (cntReg == 5'h00) stateReg <= PPF_WAIT;
					else cntReg <= cntReg - 5'h01;
				end
				PPF_WAIT: begin
					if (hsFall) stateReg <= PPF_IDLE;
				end
				default: stateReg <= PPF_IDLE;
			endcase
		end
	end

	// data pin latch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dataLatchReg <= PPF_DATA_RESET;
		end else if (startByte) begin
			dataLatchReg <= fifoHead;
		end else if (portWrite && !fifoPush && !fifoModeReg) begin
			dataLatchReg <= busData;
		end
	end

	// interrupt pending flags, set wins over clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pendLatchedReg <= 1'b0;
			pendPulseReg   <= 1'b0;
		end else begin
			if (pendSet || hsFall) pendLatchedReg <= 1'b1;
			else if (statusRead) pendLatchedReg <= 1'b0;
			if (pendSet) pendPulseReg <= 1'b1;
			else if (portWrite) pendPulseReg <= 1'b0;
		end
	end

	// registered pin and bus outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			hostDataOutReg <= 8'h00;
			hostDataOeNReg <= 1'b1;
			strobeOeNReg   <= 1'b1;
			autoOeNReg     <= 1'b1;
			initOeNReg     <= 1'b0;
			chooseOeNReg   <= 1'b1;
			dataOeNReg     <= 1'b0;
			irqReg         <= 1'b1;
			irqOeNReg      <= 1'b1;
		end else begin
			hostDataOutReg <= readMux;
			hostDataOeNReg <= ~rdLvl;
			strobeOeNReg   <= ~strobeWant;
			autoOeNReg     <= ~conReg[PPF_CON_AUTO];
			initOeNReg     <= conReg[PPF_CON_INIT];
			chooseOeNReg   <= ~conReg[PPF_CON_CHOOSE];
			dataOeNReg     <= conReg[PPF_CON_DIR];
			irqReg         <= irqNext;
			irqOeNReg      <= ~conReg[PPF_CON_IRQEN];
		end
	end

	assign hostDataOut        = hostDataOutReg;
	assign hostDataOeN        = hostDataOeNReg;
	assign printerDataPinsOut = dataLatchReg;
	assign printerDataPinsOeN = dataOeNReg;
	assign strobeNOut         = 1'b0;
	assign strobeOeN          = strobeOeNReg;
	assign autoLineFeedNOut   = 1'b0;
	assign autoLineFeedOeN    = autoOeNReg;
	assign initOut            = 1'b0;
	assign initOeN            = initOeNReg;
	assign printerChooseNOut  = 1'b0;
	assign printerChooseOeN   = chooseOeNReg;
	assign irqOut             = irqReg;
	assign irqOeN             = irqOeNReg;

	// checks
	chk_fifo_off_mode: assert property (@(posedge clk) disable iff (!rst_b)
		!fifoEn |=> !fifoModeReg)
		else $error("fifo mode without enable");
	chk_init_clears: assert property (@(posedge clk) disable iff (!rst_b)
		initEdge |=> (fifoCount == '0))
		else $error("init change did not clear fifo");
	chk_depth_bound: assert property (@(posedge clk) disable iff (!rst_b)
		fifoCount <= CW'(PPF_FIFO_DEPTH))
		else $error("fifo count beyond depth");
	chk_init_strobe: assert property (@(posedge clk) disable iff (!rst_b)
		initLow |=> strobeOeN)
		else $error("strobe driven while init low");
	chk_manual_strobe: assert property (@(posedge clk) disable iff (!rst_b)
		(!fifoModeReg && !initLow) |=> (strobeOeN == !$past(conReg[PPF_CON_STROBE])))
		else $error("manual strobe mismatch");
	chk_width_start: assert property (@(posedge clk) disable iff (!rst_b)
		(fifoModeReg && stateReg == PPF_DELAY && cntReg == 5'h00)
		|=> (stateReg == PPF_WIDTH && cntReg == $past(widthClks) - 5'h01))
		else $error("strobe width not loaded");
	chk_count_inc: assert property (@(posedge clk) disable iff (!rst_b)
		(fifoPush && fifoInReady && !fifoPop && !initEdge)
		|=> (fifoCount == $past(fifoCount) + 1'b1))
		else $error("count did not increment");
	chk_full_drop: assert property (@(posedge clk) disable iff (!rst_b)
		(fifoPush && !fifoInReady && !fifoPop && !initEdge) |=> $stable(fifoCount))
		else $error("write into full fifo counted");
	chk_latched_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(statusRead && !pendSet && !hsFall) |=> !pendLatchedReg ##1 hostDataOut[2])
		else $error("status read did not clear latched interrupt");

	cov_enter_fifo: cover property (@(posedge clk) disable iff (!rst_b) $rose(fifoModeReg));
	cov_strobe_pulse: cover property (@(posedge clk) disable iff (!rst_b)
		stateReg == PPF_WIDTH ##1 stateReg == PPF_WAIT);
	cov_fifo_full: cover property (@(posedge clk) disable iff (!rst_b) !fifoInReady);
	cov_init_pop: cover property (@(posedge clk) disable iff (!rst_b) readPop);

endmodule // ppf_printer_port

/* sim/ppf_printer_model.sv */
module ppf_printer_model (
	input  wire logic       clk,
	input  wire logic       strobeN,
	input  wire logic [7:0] dataPins,
	input  wire logic       respond,
	input  wire logic       stall,
	input  wire logic       useBusy,
	output logic            ackN,
	output logic            busy,
	output logic      [7:0] lastByte,
	output int              byteCount,
	output int              lastWidth
);
	timeunit 1ns;
	timeprecision 1ps;

	// takes a byte on each strobe, then answers with ack pulse or busy fall
	initial begin
		ackN = 1'b1;
		busy = 1'b0;
		lastByte = 8'h00;
		byteCount = 0;
		lastWidth = 0;
		forever begin
			@(posedge clk);
			if (strobeN === 1'b0 && respond) begin
				lastByte = dataPins;
				lastWidth = 0;
				busy <= useBusy;
				while (strobeN === 1'b0) begin
					lastWidth++;
					@(posedge clk);
				end
				byteCount++;
				while (stall) @(posedge clk);
				repeat (2) @(posedge clk);
				if (useBusy) begin
					busy <= 1'b0;
				end else begin
					ackN <= 1'b0;
					repeat (3) @(posedge clk);
					ackN <= 1'b1;
				end
			end
		end
	end
endmodule // ppf_printer_model

/* sim/tb_ppf_printer_port.sv */
module tb_ppf_printer_port
	import ppf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       clk, rst_b, csN, hostReadN, hostWriteN;
	logic [1:0] addr;
	logic [7:0] hostDataIn, hostDataOut, pinsOut, pinsIn, extData, lastByte;
	logic       hostDataOeN, pinsOeN, strobeNOut, strobeOeN, autoOut, autoOeN;
	logic       initOut, initOeN, chooseOut, chooseOeN, irqOut, irqOeN;
	logic       errorN, printerOnline, paperOut, busy, ackN, irqLatchModePin;
	logic       respond, stall, useBusy;
	wire        strobeW, autoW, initW, chooseW;
	int         byteCount, lastWidth, failures, totalChecks, b;
	logic [7:0] q;
	int         widthTbl [8] = '{4, 8, 8, 16, 2, 4, 4, 8};

	// open drain lines with pull-ups, data pins by direction
	assign strobeW = strobeOeN ? 1'b1 : strobeNOut;
	assign autoW   = autoOeN ? 1'b1 : autoOut;
	assign initW   = initOeN ? 1'b1 : initOut;
	assign chooseW = chooseOeN ? 1'b1 : chooseOut;
	assign pinsIn  = pinsOeN ? extData : pinsOut;

	ppf_printer_port DUT (.clk(clk), .rst_b(rst_b), .csN(csN), .hostReadN(hostReadN),
		.hostWriteN(hostWriteN), .addr(addr), .hostDataIn(hostDataIn),
		.hostDataOut(hostDataOut), .hostDataOeN(hostDataOeN), .printerDataPinsIn(pinsIn),
		.printerDataPinsOut(pinsOut), .printerDataPinsOeN(pinsOeN), .strobeNIn(strobeW),
		.strobeNOut(strobeNOut), .strobeOeN(strobeOeN), .autoLineFeedNIn(autoW),
		.autoLineFeedNOut(autoOut), .autoLineFeedOeN(autoOeN), .initIn(initW),
		.initOut(initOut), .initOeN(initOeN), .printerChooseNIn(chooseW),
		.printerChooseNOut(chooseOut), .printerChooseOeN(chooseOeN), .errorN(errorN),
		.printerOnline(printerOnline), .paperOut(paperOut), .busy(busy), .ackN(ackN),
		.irqLatchModePin(irqLatchModePin), .irqOut(irqOut), .irqOeN(irqOeN));

	ppf_printer_model printer (.clk(clk), .strobeN(strobeW), .dataPins(pinsIn),
		.respond(respond), .stall(stall), .useBusy(useBusy), .ackN(ackN), .busy(busy),
		.lastByte(lastByte), .byteCount(byteCount), .lastWidth(lastWidth));

	task automatic report_and_stop();
		$display("checks %0d failures %0d", totalChecks, failures);
		if (failures == 0 && totalChecks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
		totalChecks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic checkCount(input string n, input int e, input int g);
		totalChecks++;
		if (g != e) begin
			failures++;
			$display("unexpected %s expected %0d seen %0d", n, e, g);
		end
	endtask

	// one host cycle: strobe held six clocks, idle six clocks
	task automatic access(input logic [1:0] a, input logic w, input logic [7:0] d);
		addr <= a;
		hostDataIn <= d;
		csN <= 1'b0;
		if (w) hostWriteN <= 1'b0;
		else hostReadN <= 1'b0;
		repeat (6) @(posedge clk);
		q = hostDataOut;
		if (!w) check8("read enable", 8'h00, {7'h00, hostDataOeN});
		csN <= 1'b1;
		hostWriteN <= 1'b1;
		hostReadN <= 1'b1;
		repeat (6) @(posedge clk);
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		access(a, 1'b1, d);
	endtask

	task automatic rdChk(input string n, input logic [1:0] a, input logic [7:0] e,
		input logic [7:0] m);
		access(a, 1'b0, 8'h00);
		check8(n, e, q & m);
	endtask

	task automatic waitBytes(input int n);
		for (int k = 0; k < 400 && byteCount < n; k++) @(posedge clk);
		// let the handshake of that byte finish before the next setup
		repeat (12) @(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#300000;
		failures++;
		report_and_stop();
	end

	initial begin
		{rst_b, hostReadN, hostWriteN, csN} = 4'h7;
		{addr, hostDataIn, extData} = 18'h00000;
		{errorN, printerOnline, paperOut, irqLatchModePin} = 4'hA;
		{respond, stall, useBusy, failures, totalChecks} = 0;
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		check8("data direction", 8'h00, {7'h00, pinsOeN});
		rdChk("readback", PPF_ADDR_PINS, 8'hE0, 8'hFF);
		rdChk("count", PPF_ADDR_EXTRA, 8'h80, 8'hFF);
		wr(PPF_ADDR_PINS, 8'h1F);
		rdChk("readback", PPF_ADDR_PINS, 8'hFF, 8'hFF);
		check8("irq enable", 8'h00, {7'h00, irqOeN});
		check8("irq latched", 8'h00, {7'h00, irqOut});
		rdChk("status", PPF_ADDR_STATUS, 8'hEB, 8'hFB);
		rdChk("status", PPF_ADDR_STATUS, 8'hEF, 8'hFF);
		check8("irq cleared", 8'h01, {7'h00, irqOut});
		irqLatchModePin <= 1'b1;
		wr(PPF_ADDR_PINS, 8'h15);
		check8("irq pulse", 8'h00, {7'h00, irqOut});
		wr(PPF_ADDR_PORT, 8'hA5);
		check8("irq pulse end", 8'h01, {7'h00, irqOut});
		check8("data pins", 8'hA5, pinsOut);
		wr(PPF_ADDR_EXTRA, 8'h40);
		check8("irq inverted", 8'h00, {7'h00, irqOut});
		wr(PPF_ADDR_EXTRA, 8'h90);
		check8("irq empty", 8'h00, {7'h00, irqOut});
		wr(PPF_ADDR_EXTRA, 8'hA0);
		check8("irq full", 8'h01, {7'h00, irqOut});
		wr(PPF_ADDR_EXTRA, 8'hB0);
		rdChk("status low bits", PPF_ADDR_STATUS, 8'h00, 8'h03);
		wr(PPF_ADDR_PINS, 8'h34);
		extData <= 8'h3C;
		rdChk("port input", PPF_ADDR_PORT, 8'h3C, 8'hFF);
		wr(PPF_ADDR_PINS, 8'h14);
		respond <= 1'b1;
		wr(PPF_ADDR_EXTRA, 8'h80);
		wr(PPF_ADDR_PORT, 8'h11);
		rdChk("count", PPF_ADDR_EXTRA, 8'h00, 8'hFF);
		wr(PPF_ADDR_PINS, 8'h15);
		wr(PPF_ADDR_PINS, 8'h14);
		waitBytes(1);
		check8("first byte", 8'h11, lastByte);
		for (int i = 0; i < 8; i++) begin
			useBusy <= (i > 5);
			wr(PPF_ADDR_EXTRA, 8'h80 | 8'(i) | ((i > 5) ? 8'h08 : 8'h00));
			wr(PPF_ADDR_PORT, 8'h20 + 8'(i));
			waitBytes(i + 2);
			check8("queued byte", 8'h20 + 8'(i), lastByte);
			checkCount("strobe width", widthTbl[i], lastWidth);
		end
		useBusy <= 1'b0;
		wr(PPF_ADDR_PINS, 8'h15);
		check8("strobe ignored", 8'h01, {7'h00, strobeOeN});
		wr(PPF_ADDR_PINS, 8'h14);
		stall <= 1'b1;
		wr(PPF_ADDR_EXTRA, 8'h80);
		b = byteCount;
		for (int i = 0; i < 84; i++) wr(PPF_ADDR_PORT, 8'(i));
		rdChk("count full", PPF_ADDR_EXTRA, 8'h53, 8'hFF);
		rdChk("status full", PPF_ADDR_STATUS, 8'h00, 8'h80);
		stall <= 1'b0;
		for (int k = 0; k < 400; k++) begin
			access(PPF_ADDR_EXTRA, 1'b0, 8'h00);
			if (q === 8'h00) break;
		end
		check8("count drained", 8'h00, q);
		checkCount("bytes printed", b + 83, byteCount);
		check8("last byte", 8'h52, lastByte);
		stall <= 1'b1;
		wr(PPF_ADDR_PORT, 8'hE1);
		wr(PPF_ADDR_PORT, 8'hE2);
		wr(PPF_ADDR_PINS, 8'h10);
		respond <= 1'b0;
		stall <= 1'b0;
		rdChk("count init", PPF_ADDR_EXTRA, 8'h00, 8'hFF);
		wr(PPF_ADDR_PORT, 8'h5A);
		wr(PPF_ADDR_PORT, 8'hC3);
		rdChk("count two", PPF_ADDR_EXTRA, 8'h02, 8'hFF);
		rdChk("pop first", PPF_ADDR_PORT, 8'h5A, 8'hFF);
		rdChk("pop second", PPF_ADDR_PORT, 8'hC3, 8'hFF);
		rdChk("count popped", PPF_ADDR_EXTRA, 8'h00, 8'hFF);
		check8("strobe high", 8'h01, {7'h00, strobeOeN});
		wr(PPF_ADDR_PINS, 8'h14);
		wr(PPF_ADDR_PORT, 8'h77);
		check8("latch after init", 8'h77, pinsOut);
		check8("no strobe", 8'h01, {7'h00, strobeOeN});
		report_and_stop();
	end
endmodule // tb_ppf_printer_port
